// ==== core/olk_pkg.sv ====
// Purpose: Shared constants for the OTP register and lock block.
// Assumes: One clock, REF_CLK at 100 MHz, both ends on it.
// Notes:   Offsets are word offsets in the identifier space.
package olk_pkg;
    localparam int ADDR_W = 18;
    localparam int OFS_W  = 9;
    localparam int DATA_W = 16;
    localparam int HI_LSB = 17;

    localparam logic [7:0] CMD_READ_ARRAY  = 8'hFF;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STAT  = 8'h50;
    localparam logic [7:0] CMD_PROG_OTP    = 8'hC0;
    localparam logic [7:0] CMD_PROG_LOCK   = 8'hC4;

    localparam logic [8:0] OFS_LOCK0    = 9'h080;
    localparam logic [8:0] OFS_FACT_LO  = 9'h081;
    localparam logic [8:0] OFS_FACT_HI  = 9'h084;
    localparam logic [8:0] OFS_USER0_HI = 9'h088;
    localparam logic [8:0] OFS_LOCK1    = 9'h089;
    localparam logic [8:0] OFS_REG1_LO  = 9'h08A;
    localparam logic [8:0] OFS_LAST     = 9'h109;
    localparam int NUM_REGS  = 17;
    localparam int SEG_WORDS = 8;
    localparam int NUM_WORDS = SEG_WORDS * (2 * NUM_REGS - 1) / 2 + 4;

    localparam logic [15:0] WORD_BLANK    = 16'hFFFF;
    localparam logic [15:0] LOCK0_FACTORY = 16'hFFFE;
    localparam logic [15:0] LOCK_USER0    = 16'hFFFD;
    localparam logic [15:0] UNMAPPED_WORD = 16'h0000;

    localparam int ST_READY = 7;
    localparam int ST_PERR  = 4;
    localparam int ST_LERR  = 1;

    localparam int CLK_NS       = 10;
    localparam int PROG_TIME_NS = 500;
    localparam int PROG_CYCLES  = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;

    localparam logic [2:0] HR_ADDR     = 3'h0;
    localparam logic [2:0] HR_WDATA    = 3'h1;
    localparam logic [2:0] HR_CTRL     = 3'h2;
    localparam logic [2:0] HR_RESULT   = 3'h3;
    localparam logic [2:0] HR_IRQ_STAT = 3'h4;
    localparam logic [2:0] HR_IRQ_MASK = 3'h5;
    localparam logic [2:0] HR_FSTATUS  = 3'h6;
    localparam logic [1:0] OP_READ_ID   = 2'h0;
    localparam logic [1:0] OP_PROG_OTP  = 2'h1;
    localparam logic [1:0] OP_PROG_LOCK = 2'h2;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_PERR = 1;
    localparam int IRQ_LERR = 2;
endpackage

// ==== core/olk_if.sv ====
// Purpose: Flash bus between host controller and OTP device.
// Assumes: Both ends clocked by REF_CLK; strobes one cycle.
// Notes:   Read data returned the cycle after re, with rvalid.
`timescale 1ns/1ps
interface olk_if;
    logic [olk_pkg::ADDR_W-1:0] addr;
    logic [olk_pkg::DATA_W-1:0] wdata;
    logic                       we;
    logic                       re;
    logic [olk_pkg::DATA_W-1:0] rdata;
    logic                       rvalid;
    modport dev  (input addr, input wdata, input we, input re,
                  output rdata, output rvalid);
    modport host (output addr, output wdata, output we, output re,
                  input rdata, input rvalid);
endinterface

// ==== core/olk_dev.sv ====
// Purpose: OTP register, lock word and status logic of the flash.
// Assumes: Host keeps command order; same clock as host.
// Notes:   OTP storage has no reset; it models nonvolatile cells.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module olk_dev #(
    parameter bit          TOP_PARAM  = 1'b1,
    parameter logic [63:0] FACTORY_ID = 64'h5A5A_1234_C3C3_0F0F,
    parameter int          PROG_CYC   = olk_pkg::PROG_CYCLES
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    olk_if.dev               BUS,
    output logic             BUSY,
    output logic [15:0]      STATUS_WORD
);
    // FACTORY_ID default value is arbitrary

    typedef enum logic [2:0] {
        MD_ARRAY     = 3'b000,
        MD_ID        = 3'b001,
        MD_STATUS    = 3'b010,
        MD_WAIT_OTP  = 3'b011,
        MD_WAIT_LOCK = 3'b100,
        MD_BUSY      = 3'b101
    } olk_mode_e;

    localparam int NW = olk_pkg::NUM_WORDS;

    olk_mode_e   mode_r;
    olk_mode_e   mode_nxt;
    logic [8:0]  tgt_r;
    logic [15:0] pdata_r;
    logic        plock_r;
    logic [15:0] cnt_r;
    logic        perr_r;
    logic        lerr_r;
    logic [15:0] rdata_r;
    logic        rvalid_r;
    logic        set_perr;
    logic        set_lerr;
    logic        clr_flags;
    logic        start;
    logic        commit;
    // Programmed-bit masks; zero means still erased, no reset on RST
    logic [15:0] zero_r [NW] = '{default: 16'h0000};
    logic [15:0] lz0_r = 16'h0000;
    logic [15:0] lz1_r = 16'h0000;

    wire  [8:0]  ofs   = BUS.addr[olk_pkg::OFS_W-1:0];
    wire  [7:0]  cmd   = BUS.wdata[7:0];
    wire         hi_ok = !TOP_PARAM ||
                         (&BUS.addr[olk_pkg::ADDR_W-1:olk_pkg::HI_LSB]);
    wire  [15:0] lock0 = olk_pkg::LOCK0_FACTORY & ~lz0_r;
    wire  [15:0] lock1 = olk_pkg::WORD_BLANK & ~lz1_r;

    function automatic logic is_otp(input logic [8:0] o);
        is_otp = (o >= olk_pkg::OFS_FACT_LO && o <= olk_pkg::OFS_USER0_HI)
              || (o >= olk_pkg::OFS_REG1_LO && o <= olk_pkg::OFS_LAST);
    endfunction

    // Word index: 0..7 register 0, 8.. registers 1 to 16
    function automatic logic [7:0] widx(input logic [8:0] o);
        logic [8:0] d;
        d = (o <= olk_pkg::OFS_USER0_HI) ? o - olk_pkg::OFS_FACT_LO
                                         : o - 9'h002 - olk_pkg::OFS_LOCK0;
        widx = d[7:0];
    endfunction

    function automatic logic is_locked(input logic [8:0] o,
                                       input logic [15:0] l0,
                                       input logic [15:0] l1);
        logic [8:0] r;
        r = (o - olk_pkg::OFS_REG1_LO) >> 3;
        if (o <= olk_pkg::OFS_FACT_HI)
            is_locked = !l0[0];
        else if (o <= olk_pkg::OFS_USER0_HI)
            is_locked = !l0[1];
        else
            is_locked = !l1[r[3:0]];
    endfunction

    // Factory words keep their ID pattern; all other words ship blank
    function automatic logic [15:0] word_val(input logic [7:0] i,
                                             input logic [15:0] z);
        logic [15:0] base;
        base = (i < 8'd4) ? FACTORY_ID[16*i +: 16]
                          : olk_pkg::WORD_BLANK;
        word_val = base & ~z;
    endfunction

    // Command decode and program sequencing
    always_comb begin
        mode_nxt  = mode_r;
        set_perr  = 1'b0;
        set_lerr  = 1'b0;
        clr_flags = 1'b0;
        start     = 1'b0;
        commit    = 1'b0;
        unique case (mode_r)
            MD_BUSY: begin
                if (cnt_r == 16'h0000) begin
                    commit   = 1'b1;
                    mode_nxt = MD_STATUS;
                end
            end
            MD_WAIT_OTP: begin
                if (BUS.we) begin
                    mode_nxt = MD_STATUS;
                    if (ofs != tgt_r)
                        set_perr = 1'b1;
                    else if (is_locked(tgt_r, lock0, lock1)) begin
                        set_perr = 1'b1;
                        set_lerr = 1'b1;
                    end else begin
                        start    = 1'b1;
                        mode_nxt = MD_BUSY;
                    end
                end
            end
            MD_WAIT_LOCK: begin
                if (BUS.we) begin
                    start    = 1'b1;
                    mode_nxt = MD_BUSY;
                end
            end
            default: begin
                if (BUS.we) begin
                    case (cmd)
                        olk_pkg::CMD_READ_ARRAY:  mode_nxt = MD_ARRAY;
                        olk_pkg::CMD_READ_ID:     mode_nxt = MD_ID;
                        olk_pkg::CMD_READ_STATUS: mode_nxt = MD_STATUS;
                        olk_pkg::CMD_CLEAR_STAT:  clr_flags = 1'b1;
                        olk_pkg::CMD_PROG_OTP: begin
                            if (is_otp(ofs) && hi_ok)
                                mode_nxt = MD_WAIT_OTP;
                            else begin
                                set_perr = 1'b1;
                                mode_nxt = MD_STATUS;
                            end
                        end
                        olk_pkg::CMD_PROG_LOCK: begin
                            if (ofs == olk_pkg::OFS_LOCK0 ||
                                ofs == olk_pkg::OFS_LOCK1)
                                mode_nxt = MD_WAIT_LOCK;
                            else begin
                                set_perr = 1'b1;
                                mode_nxt = MD_STATUS;
                            end
                        end
                        default: mode_nxt = mode_r;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            mode_r  <= MD_ARRAY;
            tgt_r   <= 9'h000;
            pdata_r <= 16'hFFFF;
            plock_r <= 1'b0;
            cnt_r   <= 16'h0000;
        end else begin
            mode_r <= mode_nxt;
            if (mode_r != MD_BUSY && BUS.we &&
                (mode_nxt == MD_WAIT_OTP || mode_nxt == MD_WAIT_LOCK)) begin
                tgt_r   <= ofs;
                plock_r <= (mode_nxt == MD_WAIT_LOCK);
            end
            if (start) begin
                pdata_r <= BUS.wdata;
                cnt_r   <= 16'(PROG_CYC - 1);
            end else if (cnt_r != 16'h0000)
                cnt_r <= cnt_r - 16'h0001;
        end
    end

    // Error flags: a new error beats a same-cycle clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            perr_r <= 1'b0;
            lerr_r <= 1'b0;
        end else begin
            perr_r <= set_perr | (perr_r & ~clr_flags);
            lerr_r <= set_lerr | (lerr_r & ~clr_flags);
        end
    end

    // OTP cells: only ones become zeros, never back
    always_ff @(posedge REF_CLK) begin
        if (commit && !plock_r)
            zero_r[widx(tgt_r)] <= zero_r[widx(tgt_r)] | ~pdata_r;
        if (commit && plock_r && tgt_r == olk_pkg::OFS_LOCK0)
            lz0_r <= lz0_r | ~pdata_r;
        if (commit && plock_r && tgt_r == olk_pkg::OFS_LOCK1)
            lz1_r <= lz1_r | ~pdata_r;
    end

    // Read path, data one cycle after the read strobe
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= BUS.re;
            if (BUS.re) begin
                if (mode_r == MD_ARRAY)
                    rdata_r <= olk_pkg::WORD_BLANK;
                else if (mode_r != MD_ID)
                    rdata_r <= STATUS_WORD;
                else if (ofs == olk_pkg::OFS_LOCK0)
                    rdata_r <= lock0;
                else if (ofs == olk_pkg::OFS_LOCK1)
                    rdata_r <= lock1;
                else if (is_otp(ofs))
                    rdata_r <= word_val(widx(ofs), zero_r[widx(ofs)]);
                else
                    rdata_r <= olk_pkg::UNMAPPED_WORD;
            end
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            BUSY        <= 1'b0;
            STATUS_WORD <= 16'h0080;
        end else begin
            BUSY <= (mode_nxt == MD_BUSY);
            STATUS_WORD <= 16'h0000;
            STATUS_WORD[olk_pkg::ST_READY] <= (mode_nxt != MD_BUSY);
            STATUS_WORD[olk_pkg::ST_PERR]  <= set_perr |
                                              (perr_r & ~clr_flags);
            STATUS_WORD[olk_pkg::ST_LERR]  <= set_lerr |
                                              (lerr_r & ~clr_flags);
        end
    end

    assign BUS.rdata  = rdata_r;
    assign BUS.rvalid = rvalid_r;
endmodule // olk_dev

// ==== core/olk_host.sv ====
// Purpose: Host controller issuing OTP read, program, lock sequences.
// Assumes: Same clock as device; software on plain register port.
// Notes:   One operation at a time; CTRL writes while busy ignored.
`timescale 1ns/1ps
module olk_host #(
    parameter bit TOP_PARAM = 1'b1
) (
    input  wire logic        REF_CLK,
    input  wire logic        RST,
    olk_if.host              BUS,
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [15:0]      RDATA,
    output logic             IRQ
);
    typedef enum logic [3:0] {
        HS_IDLE  = 4'b0000,
        HS_READ  = 4'b0001,
        HS_WAITR = 4'b0010,
        HS_DATA  = 4'b0011,
        HS_POLL  = 4'b0100,
        HS_WAITP = 4'b0101,
        HS_CLEAR = 4'b0110,
        HS_EXIT  = 4'b0111,
        HS_END   = 4'b1000
    } olk_hstate_e;

    olk_hstate_e st_r;
    logic [8:0]  ofs_r;
    logic [15:0] wd_r;
    logic [15:0] result_r;
    logic [15:0] fstat_r;
    logic [2:0]  irq_stat_r;
    logic [2:0]  irq_mask_r;
    logic [2:0]  ev;
    logic [olk_pkg::ADDR_W-1:0] baddr_r;
    logic [15:0] bwd_r;
    logic        we_r;
    logic        re_r;

    wire start = WR && ADDR == olk_pkg::HR_CTRL && st_r == HS_IDLE;
    // Upper address bits high for top-parameter parts
    wire [olk_pkg::ADDR_W-1:0] full_addr =
        {{(olk_pkg::ADDR_W-olk_pkg::OFS_W){TOP_PARAM}}, ofs_r};

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            ofs_r      <= 9'h000;
            wd_r       <= 16'hFFFF;
            irq_mask_r <= 3'h0;
        end else if (WR) begin
            if (ADDR == olk_pkg::HR_ADDR)
                ofs_r <= WDATA[8:0];
            if (ADDR == olk_pkg::HR_WDATA)
                wd_r <= WDATA;
            if (ADDR == olk_pkg::HR_IRQ_MASK)
                irq_mask_r <= WDATA[2:0];
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            st_r     <= HS_IDLE;
            result_r <= 16'h0000;
            fstat_r  <= 16'h0000;
            baddr_r  <= '0;
            bwd_r    <= 16'h0000;
            we_r     <= 1'b0;
            re_r     <= 1'b0;
            ev       <= 3'h0;
        end else begin
            we_r <= 1'b0;
            re_r <= 1'b0;
            ev   <= 3'h0;
            unique case (st_r)
                HS_IDLE: if (start) begin
                    we_r    <= 1'b1;
                    baddr_r <= full_addr;
                    if (WDATA[1:0] == olk_pkg::OP_PROG_OTP) begin
                        bwd_r <= {8'h00, olk_pkg::CMD_PROG_OTP};
                        st_r  <= HS_DATA;
                    end else if (WDATA[1:0] == olk_pkg::OP_PROG_LOCK) begin
                        bwd_r <= {8'h00, olk_pkg::CMD_PROG_LOCK};
                        st_r  <= HS_DATA;
                    end else begin
                        bwd_r <= {8'h00, olk_pkg::CMD_READ_ID};
                        st_r  <= HS_READ;
                    end
                end
                HS_READ: begin
                    re_r <= 1'b1;
                    st_r <= HS_WAITR;
                end
                HS_WAITR: if (BUS.rvalid) begin
                    result_r <= BUS.rdata;
                    st_r     <= HS_EXIT;
                end
                HS_DATA: begin
                    we_r  <= 1'b1;
                    bwd_r <= wd_r;
                    st_r  <= HS_POLL;
                end
                HS_POLL: begin
                    re_r <= 1'b1;
                    st_r <= HS_WAITP;
                end
                HS_WAITP: if (BUS.rvalid) begin
                    fstat_r <= BUS.rdata;
                    if (!BUS.rdata[olk_pkg::ST_READY])
                        st_r <= HS_POLL;
                    else if (BUS.rdata[olk_pkg::ST_PERR] ||
                             BUS.rdata[olk_pkg::ST_LERR]) begin
                        ev[olk_pkg::IRQ_PERR] <= BUS.rdata[olk_pkg::ST_PERR];
                        ev[olk_pkg::IRQ_LERR] <= BUS.rdata[olk_pkg::ST_LERR];
                        st_r <= HS_CLEAR;
                    end else
                        st_r <= HS_EXIT;
                end
                HS_CLEAR: begin
                    we_r  <= 1'b1;
                    bwd_r <= {8'h00, olk_pkg::CMD_CLEAR_STAT};
                    st_r  <= HS_EXIT;
                end
                HS_EXIT: begin
                    we_r  <= 1'b1;
                    bwd_r <= {8'h00, olk_pkg::CMD_READ_ARRAY};
                    st_r  <= HS_END;
                end
                HS_END: begin
                    ev[olk_pkg::IRQ_DONE] <= 1'b1;
                    st_r <= HS_IDLE;
                end
                default: st_r <= HS_IDLE;
            endcase
        end
    end

    // Sticky events; a new event beats a same-cycle write-one clear
    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            irq_stat_r <= 3'h0;
            IRQ        <= 1'b0;
        end else begin
            irq_stat_r <= ev | (irq_stat_r &
                          ~((WR && ADDR == olk_pkg::HR_IRQ_STAT) ?
                            WDATA[2:0] : 3'h0));
            IRQ <= |(irq_stat_r & irq_mask_r);
        end
    end

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST)
            RDATA <= 16'h0000;
        else if (RD) begin
            case (ADDR)
                olk_pkg::HR_ADDR:     RDATA <= {7'h00, ofs_r};
                olk_pkg::HR_WDATA:    RDATA <= wd_r;
                olk_pkg::HR_CTRL:     RDATA <= {15'h0000, st_r != HS_IDLE};
                olk_pkg::HR_RESULT:   RDATA <= result_r;
                olk_pkg::HR_IRQ_STAT: RDATA <= {13'h0000, irq_stat_r};
                olk_pkg::HR_IRQ_MASK: RDATA <= {13'h0000, irq_mask_r};
                olk_pkg::HR_FSTATUS:  RDATA <= fstat_r;
                default:              RDATA <= 16'h0000;
            endcase
        end
    end

    assign BUS.addr  = baddr_r;
    assign BUS.wdata = bwd_r;
    assign BUS.we    = we_r;
    assign BUS.re    = re_r;
endmodule // olk_host

// ==== tb/olk_asserts.sv ====
// Purpose: Flash bus checks between the host and device ends.
// Assumes: Single clock; PROG_CYC shortened by the bench.
// Notes:   No bind; instantiated beside the interface.
`timescale 1ns/1ps
module olk_asserts #(
    parameter int PROG_CYC = 2
) (
    input wire logic        REF_CLK,
    input wire logic        RST,
    input wire logic [17:0] addr,
    input wire logic [15:0] wdata,
    input wire logic        we,
    input wire logic        re,
    input wire logic [15:0] rdata,
    input wire logic        rvalid,
    input wire logic        BUSY,
    input wire logic [15:0] STATUS_WORD
);
    localparam int BUSY_MAX = PROG_CYC + 1;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (RST);

    chk_read_answer: assert property (
        re |=> rvalid ##1 !rvalid)
        else $error("read not answered next cycle");
    chk_read_cause: assert property (
        rvalid |-> $past(re))
        else $error("rvalid without read");
    chk_prog_pair: assert property (
        we && !$past(we) && wdata[7:0] == 8'hC0 |=> we && $stable(addr))
        else $error("program data not at command address");
    chk_top_addr: assert property (
        we && !$past(we) && wdata[7:0] == 8'hC0 |-> addr[17])
        else $error("upper address bit low on program");
    chk_lock_addr: assert property (
        we && !$past(we) && wdata[7:0] == 8'hC4
        |-> (addr[8:0] == 9'h080 || addr[8:0] == 9'h089) ##1 we)
        else $error("lock command misplaced");
    chk_busy_start: assert property (
        $rose(BUSY) |-> $past(we))
        else $error("busy without data write");
    chk_busy_len: assert property (
        $rose(BUSY) |-> ##[1:BUSY_MAX] !BUSY)
        else $error("programming too long");
    chk_lerr_pair: assert property (
        STATUS_WORD[1] |-> STATUS_WORD[4])
        else $error("lock error without program error");
    chk_lerr_idle: assert property (
        $rose(STATUS_WORD[1]) |-> !BUSY && !$past(BUSY))
        else $error("locked target was programmed");
    chk_stat_rsvd: assert property (
        (STATUS_WORD & 16'hFF6D) == 16'h0000)
        else $error("reserved status bits set");

    cov_prog: cover property ($rose(BUSY));
    cov_lerr: cover property ($rose(STATUS_WORD[1]));
    cov_lock: cover property (we && wdata[7:0] == 8'hC4);
    cov_read: cover property (rvalid && rdata == 16'hFFFF);
endmodule // olk_asserts

// ==== tb/otp_register_program_lock_bench.sv ====
// Purpose: Self-checking bench for host and device ends together.
// Assumes: Software port reads answer one cycle after RD.
// Notes:   OTP image persists across ops, so order matters.
`timescale 1ns/1ps
module otp_register_program_lock_bench;
    logic        ref_clk;
    logic        rst;
    logic [2:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        irq;
    logic        busy;
    logic [15:0] status_word;
    logic [15:0] mask;
    int          mismatches;
    int          n_tests;
    localparam logic [1:0] RID = olk_pkg::OP_READ_ID;
    localparam logic [1:0] PRG = olk_pkg::OP_PROG_OTP;
    localparam logic [1:0] PLK = olk_pkg::OP_PROG_LOCK;
    // Arbitrary factory ID so the bench knows the expected words
    localparam logic [63:0] FID = 64'h0123_4567_89AB_CDEF;

    olk_if bus ();
    olk_host i_olk_host (.REF_CLK(ref_clk), .RST(rst), .BUS(bus),
        .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq));
    // Short program time keeps the polling loops brief
    olk_dev #(.PROG_CYC(2), .FACTORY_ID(FID)) i_olk_dev (.REF_CLK(ref_clk),
        .RST(rst), .BUS(bus), .BUSY(busy), .STATUS_WORD(status_word));
    olk_asserts #(.PROG_CYC(2)) i_olk_asserts (.REF_CLK(ref_clk),
        .RST(rst), .addr(bus.addr), .wdata(bus.wdata), .we(bus.we),
        .re(bus.re), .rdata(bus.rdata), .rvalid(bus.rvalid),
        .BUSY(busy), .STATUS_WORD(status_word));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic test_done();
        if (mismatches == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // One host operation; waits on the done bit, checks the flags
    task automatic op(input logic [8:0] ofs, input logic [15:0] dat,
                      input logic [1:0] code, input logic [2:0] est,
                      output logic [15:0] res);
        logic [15:0] st;
        st = 16'h0000;
        wr_reg(olk_pkg::HR_ADDR, {7'h00, ofs});
        wr_reg(olk_pkg::HR_WDATA, dat);
        wr_reg(olk_pkg::HR_CTRL, {14'h0000, code});
        rd_reg(olk_pkg::HR_CTRL, res);
        chk(res, 16'h0001);
        for (int k = 0; k < 200 && st[0] !== 1'b1; k++)
            rd_reg(olk_pkg::HR_IRQ_STAT, st);
        rd_reg(olk_pkg::HR_RESULT, res);
        chk({13'h0000, st[2:0]}, {13'h0000, est});
        chk({15'h0000, irq}, {15'h0000, mask != 16'h0000});
        wr_reg(olk_pkg::HR_IRQ_STAT, 16'h0007);
        @(posedge ref_clk);
        #1 chk({15'h0000, irq}, 16'h0000);
    endtask

    initial begin
        logic [15:0] d;
        logic [15:0] f;
        logic [15:0] a;
        logic [15:0] b;
        logic [8:0]  w;
        int          k;
        mismatches = 0;
        n_tests = 0;
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 16'h0000;
        mask = 16'h0000;
        void'($urandom(37));
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        op(9'h080, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFE);
        wr_reg(olk_pkg::HR_IRQ_MASK, 16'h0007);
        mask = 16'h0007;
        op(9'h089, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFF);
        op(9'h085, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFF);
        op(9'h081, 16'h0000, RID, 3'h1, f);
        chk(f, FID[15:0]);
        op(9'h084, 16'h0000, RID, 3'h1, d);
        chk(d, FID[63:48]);
        op(9'h081, 16'h0000, PRG, 3'h7, d);
        rd_reg(olk_pkg::HR_FSTATUS, d);
        chk(d, 16'h0092);
        op(9'h081, 16'h0000, RID, 3'h1, d);
        chk(d, f);
        for (k = 0; k < 4; k++) begin
            w = 9'h08A + 9'(8 * k) + 9'($urandom % 7);
            a = 16'($urandom);
            b = 16'($urandom);
            op(w, a, PRG, 3'h1, d);
            op(w, b, PRG, 3'h1, d);
            op(w, 16'h0000, RID, 3'h1, d);
            chk(d, a & b);
        end
        op(9'h010, 16'h1234, PRG, 3'h3, d);
        op(9'h080, 16'hFFFD, PLK, 3'h1, d);
        op(9'h080, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFC);
        op(9'h085, 16'h0000, PRG, 3'h7, d);
        op(9'h085, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFF);
        k = 1 + int'($urandom % 16);
        a = ~(16'h0001 << (k - 1));
        op(9'h089, a, PLK, 3'h1, d);
        op(9'h089, 16'h0000, RID, 3'h1, d);
        chk(d, a);
        w = 9'h08A + 9'(8 * (k - 1)) + 9'h007;
        op(w, 16'h0000, PRG, 3'h7, d);
        w = 9'h08A + 9'(8 * (k % 16)) + 9'h007;
        op(w, 16'h00F0, PRG, 3'h1, d);
        op(w, 16'h0000, RID, 3'h1, d);
        chk(d, 16'h00F0);
        wr_reg(olk_pkg::HR_IRQ_MASK, 16'h0000);
        mask = 16'h0000;
        op(9'h088, 16'h0000, RID, 3'h1, d);
        chk(d, 16'hFFFF);
        rd_reg(olk_pkg::HR_ADDR, d);
        chk(d, 16'h0088);
        rd_reg(3'h7, d);
        chk(d, 16'h0000);
        test_done();
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        test_done();
    end
endmodule // otp_register_program_lock_bench
